// *** core/sbg_ctrl.sv ***
// Bit clock generator with channel enable control behind an Avalon slave.
// Functional notes
// - Divisor zero stops clock; one bypasses divider.
// - Async: sampling clock, then divide 16 or 8.
// - Source: master, master over eight, external pin.
// - Clock divisor field is sixteen bits.
// - Fraction only in normal asynchronous mode.
// - Rate: clock over 8(2-over)(divisor+fraction/8).
// - Sync mode: divide by divisor only.
// - Sync with source 3: pin clock direct.
// - Master source gives even split, odd divisor.
// - Card mode: divided clock may drive pin.
// - Card clock divided by ratio up to 2047.
// - Ratio field resets to 372.
// - Receiver disabled until enable command.
// - Transmitter disabled until enable; independent enables.
// - Configuration writable while directions disabled.
// - Soft reset ends a pending disable at once; keeps configuration and enables.
// - Receiver disable waits for current character.
// - Transmitter disable waits for holding and timeguard.
`timescale 1ns/1ps
module sbg_ctrl import sbg_pkg::*; (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Avalon-MM slave.
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Serial clock pin.
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   // Framing logic side.
   input wire logic rx_busy_i,
   input wire logic tx_busy_i,
   output logic rx_en_o,
   output logic tx_en_o,
   output logic rx_soft_reset_o,
   output logic tx_soft_reset_o,
   output logic samp_tick_o,
   output logic baud_tick_o
);
   // All registered state of the block in one word.
   typedef struct packed {
      logic [3:0] opmode;
      logic [1:0] clk_sel;
      logic sync_mode;
      logic card_clock_out_en;
      logic over;
      logic [SBG_CD_W-1:0] cd;
      logic [SBG_FP_W-1:0] fp;
      logic [SBG_ETU_W-1:0] etu;
      logic rx_en;
      logic tx_en;
      logic rx_dis_pend;
      logic tx_dis_pend;
      logic rx_rst;
      logic tx_rst;
      logic ack;
      logic [31:0] rdata;
      logic [3:0] os_cnt;
      logic [SBG_ETU_W-1:0] etu_cnt;
      logic samp;
      logic baud;
      logic sck_s1;
      logic sck_s2;
      logic sck_out;
   } sbg_ctrl_state_type;

   sbg_ctrl_state_type st_r;
   sbg_ctrl_state_type st_nxt;
   // Settings to and results from the divider core.
   sbg_div_if dif ();
   // Bus decode and register image helpers.
   logic req;
   logic wr_now;
   logic iso_mode;
   logic [31:0] mode_word;
   logic [31:0] brgr_word;
   logic [31:0] fidi_word;
   logic [31:0] stat_word;
   logic [31:0] rd_mux;
   logic [31:0] wmerge;
   // Last oversampling count, 15 or 7.
   logic [3:0] os_last;

   // Merge write data into an old word under the byte enables.
   function automatic logic [31:0] sbg_merge(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] be);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Register images as software sees them.
   // Unused bits of every image read as zero.
   always_comb begin
      mode_word = 32'h00000000;
      mode_word[SBG_OPMODE_LSB +: 4] = st_r.opmode;
      mode_word[SBG_CLKSEL_LSB +: 2] = st_r.clk_sel;
      mode_word[SBG_SYNC_BIT] = st_r.sync_mode;
      mode_word[SBG_CARD_CLOCK_OUT_EN_BIT] = st_r.card_clock_out_en;
      mode_word[SBG_OVER_BIT] = st_r.over;
      brgr_word = 32'h00000000;
      brgr_word[SBG_CD_LSB +: SBG_CD_W] = st_r.cd;
      brgr_word[SBG_FP_LSB +: SBG_FP_W] = st_r.fp;
      fidi_word = {21'h000000, st_r.etu};
      stat_word = {28'h0000000, st_r.tx_dis_pend, st_r.rx_dis_pend,
         st_r.tx_en, st_r.rx_en};
   end

   // Read data selection; unmapped or misaligned addresses read zero.
   // The control register is write-only, so it also reads zero.
   always_comb begin
      unique case (avs_address_i)
         SBG_MODE_OFS: rd_mux = mode_word;
         SBG_STAT_OFS: rd_mux = stat_word;
         SBG_BRGR_OFS: rd_mux = brgr_word;
         SBG_FIDI_OFS: rd_mux = fidi_word;
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Bus handshake terms.
   // Byte lanes left disabled keep the old bits of the merged word.
   always_comb begin
      req = avs_read_i | avs_write_i;
      wr_now = avs_write_i & st_r.ack;
      iso_mode = (st_r.opmode == SBG_OPMODE_ISO_T0) ||
         (st_r.opmode == SBG_OPMODE_ISO_T1);
      os_last = st_r.over ? SBG_OS8_LAST : SBG_OS16_LAST;
      unique case (avs_address_i)
         SBG_MODE_OFS: wmerge = sbg_merge(mode_word, avs_writedata_i,
            avs_byteenable_i);
         SBG_BRGR_OFS: wmerge = sbg_merge(brgr_word, avs_writedata_i,
            avs_byteenable_i);
         SBG_FIDI_OFS: wmerge = sbg_merge(fidi_word, avs_writedata_i,
            avs_byteenable_i);
         default: wmerge = sbg_merge(32'h00000000, avs_writedata_i,
            avs_byteenable_i);
      endcase
   end

   // Next state: bus, configuration, channel enables and rate counters.
   always_comb begin
      st_nxt = st_r;
      // Ack stands one cycle per access, giving exactly one wait state.
      st_nxt.ack = req & ~st_r.ack;
      // Read data is captured while waitrequest is still high.
      if (avs_read_i && !st_r.ack) begin
         st_nxt.rdata = rd_mux;
      end
      // Soft reset outputs are single cycle pulses.
      st_nxt.rx_rst = 1'b0;
      st_nxt.tx_rst = 1'b0;
      // Configuration writes are taken in any enable state.
      // Command writes to the control register are handled below.
      if (wr_now) begin
         unique case (avs_address_i)
            SBG_MODE_OFS: begin
               st_nxt.opmode = wmerge[SBG_OPMODE_LSB +: 4];
               st_nxt.clk_sel = wmerge[SBG_CLKSEL_LSB +: 2];
               st_nxt.sync_mode = wmerge[SBG_SYNC_BIT];
               st_nxt.card_clock_out_en = wmerge[SBG_CARD_CLOCK_OUT_EN_BIT];
               st_nxt.over = wmerge[SBG_OVER_BIT];
            end
            SBG_BRGR_OFS: begin
               st_nxt.cd = wmerge[SBG_CD_LSB +: SBG_CD_W];
               st_nxt.fp = wmerge[SBG_FP_LSB +: SBG_FP_W];
            end
            SBG_FIDI_OFS: begin
               st_nxt.etu = wmerge[SBG_ETU_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // A pending disable completes once the direction has gone idle.
      // It is applied before the commands so that a new enable wins.
      if (st_r.rx_dis_pend && (!rx_busy_i || st_r.rx_rst)) begin
         st_nxt.rx_en = 1'b0;
         st_nxt.rx_dis_pend = 1'b0;
      end
      if (st_r.tx_dis_pend && (!tx_busy_i || st_r.tx_rst)) begin
         st_nxt.tx_en = 1'b0;
         st_nxt.tx_dis_pend = 1'b0;
      end
      // Commands; disable beats enable when both are written together.
      // Command bits sit in byte lane 0 and are not stored.
      if (wr_now && avs_address_i == SBG_CTRL_OFS &&
         avs_byteenable_i[0]) begin
         if (avs_writedata_i[SBG_RX_ENABLE_BIT]) begin
            st_nxt.rx_en = 1'b1;
            st_nxt.rx_dis_pend = 1'b0;
         end
         if (avs_writedata_i[SBG_TX_ENABLE_BIT]) begin
            st_nxt.tx_en = 1'b1;
            st_nxt.tx_dis_pend = 1'b0;
         end
         if (avs_writedata_i[SBG_RX_DISABLE_BIT]) begin
            st_nxt.rx_dis_pend = st_nxt.rx_en;
         end
         if (avs_writedata_i[SBG_TX_DISABLE_BIT]) begin
            st_nxt.tx_dis_pend = st_nxt.tx_en;
         end
         st_nxt.rx_rst = avs_writedata_i[SBG_RX_SOFT_RESET_BIT];
         st_nxt.tx_rst = avs_writedata_i[SBG_TX_SOFT_RESET_BIT];
      end
      // Pin clock synchroniser; the first stage feeds only the second.
      // The far side keeps its clock well below the system clock.
      st_nxt.sck_s1 = sck_i;
      st_nxt.sck_s2 = st_r.sck_s1;
      // Post divider: oversampling, bit clock or card time unit.
      st_nxt.samp = 1'b0;
      st_nxt.baud = 1'b0;
      if (dif.div_tick) begin
         // Every divided clock is a sampling clock tick.
         st_nxt.samp = 1'b1;
         // Card modes count the time unit ratio; zero stops the bit clock.
         if (iso_mode) begin
            if (st_r.etu != '0 && st_r.etu_cnt >= st_r.etu - 11'h001) begin
               st_nxt.etu_cnt = '0;
               st_nxt.baud = 1'b1;
            end else if (st_r.etu != '0) begin
               st_nxt.etu_cnt = st_r.etu_cnt + 11'h001;
            end
         end else if (st_r.sync_mode) begin
            // Synchronous mode takes every divided clock as a bit.
            st_nxt.baud = 1'b1;
         end else if (st_r.os_cnt >= os_last) begin
            // Asynchronous mode oversamples by 16 or by 8.
            st_nxt.os_cnt = 4'h0;
            st_nxt.baud = 1'b1;
         end else begin
            st_nxt.os_cnt = st_r.os_cnt + 4'h1;
         end
      end
      // Registered pin level for the sources that need no balancing.
      st_nxt.sck_out = dif.sck_lvl;
   end

   // State register.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         // Configuration fields take reset values, the rest clears.
         st_r <= '0;
         st_r.etu <= SBG_ETU_RST;
         st_r.cd <= SBG_CD_RST;
         st_r.fp <= SBG_FP_RST;
         st_r.opmode <= SBG_OPMODE_RST;
         st_r.clk_sel <= SBG_CLKSEL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Divider settings handed to the divider core.
   // Fractional steps are barred in card and synchronous modes.
   assign dif.clk_sel = st_r.clk_sel;
   assign dif.cd = st_r.cd;
   assign dif.fp = st_r.fp;
   assign dif.frac_allowed = (st_r.opmode == SBG_OPMODE_NORMAL) &&
      !st_r.sync_mode;
   assign dif.sync_mode = st_r.sync_mode & ~iso_mode;
   assign dif.ext_sck_lvl = st_r.sck_s2;

   // Source select with integer and fractional division.
   sbg_divider u_div (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .dif(dif)
   );

   // Outputs.
   // Channel enables and pulses come straight from flops.
   // Waitrequest is combinational so a new request stalls at once.
   assign avs_waitrequest_o = req & ~st_r.ack;
   assign avs_readdata_o = st_r.rdata;
   assign rx_en_o = st_r.rx_en;
   assign tx_en_o = st_r.tx_en;
   assign rx_soft_reset_o = st_r.rx_rst;
   assign tx_soft_reset_o = st_r.tx_rst;
   assign samp_tick_o = st_r.samp;
   assign baud_tick_o = st_r.baud;
   // Master clock source uses the half-cycle balanced level directly.
   assign sck_o = (st_r.clk_sel == SBG_SRC_MCK) ? dif.sck_lvl : st_r.sck_out;
   // Pin is driven in card mode with card clock output set, internal source.
   assign sck_oe_o = st_r.card_clock_out_en & iso_mode &
      (st_r.clk_sel != SBG_SRC_EXT);
endmodule

// *** core/sbg_div_if.sv ***
// Interface carrying divider settings and divider outputs between modules.
`timescale 1ns/1ps
interface sbg_div_if;
   import sbg_pkg::*;
   logic [1:0] clk_sel;
   logic [SBG_CD_W-1:0] cd;
   logic [SBG_FP_W-1:0] fp;
   logic frac_allowed;
   logic sync_mode;
   logic ext_sck_lvl;
   logic div_tick;
   logic sck_lvl;
   modport ctrl (output clk_sel, cd, fp, frac_allowed, sync_mode,
      ext_sck_lvl, input div_tick, sck_lvl);
   modport div (input clk_sel, cd, fp, frac_allowed, sync_mode,
      ext_sck_lvl, output div_tick, sck_lvl);
endinterface

// *** core/sbg_divider.sv ***
// Clock source selection and integer plus fractional divider.
`timescale 1ns/1ps
module sbg_divider import sbg_pkg::*; (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Settings and results.
   sbg_div_if.div dif
);
   typedef struct packed {
      logic [2:0] pre_cnt;
      logic [SBG_CD_W-1:0] cnt;
      logic [SBG_FP_W-1:0] acc;
      logic stretch;
      logic ext_d;
      logic tick;
      logic phase;
   } sbg_div_state_type;

   sbg_div_state_type st_r;
   sbg_div_state_type st_nxt;
   logic phase_neg_r;
   logic src_en;
   logic ext_rise;
   logic frac_on;
   logic [SBG_CD_W:0] last;
   logic [SBG_FP_W:0] acc_sum;

   // Source enable, period length and fractional accumulation.
   always_comb begin
      ext_rise = dif.ext_sck_lvl & ~st_r.ext_d;
      unique case (dif.clk_sel)
         SBG_SRC_MCK: src_en = 1'b1;
         SBG_SRC_MCK_DIV: src_en = (st_r.pre_cnt == SBG_PRE_LAST);
         default: src_en = ext_rise;
      endcase
      frac_on = dif.frac_allowed && (dif.fp != SBG_FP_RST);
      last = {1'b0, dif.cd} - 17'h00001 + {16'h0000, st_r.stretch};
      acc_sum = {1'b0, st_r.acc} + {1'b0, dif.fp};
      st_nxt = st_r;
      st_nxt.pre_cnt = st_r.pre_cnt + 3'h1;
      st_nxt.ext_d = dif.ext_sck_lvl;
      st_nxt.tick = 1'b0;
      if (dif.sync_mode && dif.clk_sel == SBG_SRC_EXT) begin
         st_nxt.tick = ext_rise;
         st_nxt.cnt = '0;
      end else if (dif.cd == SBG_CD_RST) begin
         st_nxt.cnt = '0;
         st_nxt.stretch = 1'b0;
      end else if (src_en) begin
         if ({1'b0, st_r.cnt} >= last) begin
            st_nxt.tick = 1'b1;
            st_nxt.cnt = '0;
            st_nxt.acc = frac_on ? acc_sum[SBG_FP_W-1:0] : '0;
            st_nxt.stretch = frac_on & acc_sum[SBG_FP_W];
         end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
         end
      end
      // High for the first half of the period, rounded down.
      st_nxt.phase = (st_nxt.cnt < (dif.cd >> 1));
   end

   // State register.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Half cycle late copy that stretches odd periods to an even split.
   always_ff @(negedge sys_clk_i) begin
      if (!rst_n_i) begin
         phase_neg_r <= 1'b0;
      end else begin
         phase_neg_r <= st_r.phase;
      end
   end

   assign dif.div_tick = st_r.tick;
   // Odd divisor on the master clock takes the extra half cycle.
   assign dif.sck_lvl = st_r.phase | (phase_neg_r & dif.cd[0] &
      (dif.clk_sel == SBG_SRC_MCK));
endmodule

// *** core/sbg_pkg.sv ***
// Package with register map, field layout and reset values of the block.
package sbg_pkg;
   // Register byte offsets.
   localparam logic [7:0] SBG_CTRL_OFS = 8'h00;
   localparam logic [7:0] SBG_MODE_OFS = 8'h04;
   localparam logic [7:0] SBG_STAT_OFS = 8'h14;
   localparam logic [7:0] SBG_BRGR_OFS = 8'h20;
   localparam logic [7:0] SBG_FIDI_OFS = 8'h40;
   // Control register command bits.
   localparam int SBG_RX_SOFT_RESET_BIT = 2;
   localparam int SBG_TX_SOFT_RESET_BIT = 3;
   localparam int SBG_RX_ENABLE_BIT = 4;
   localparam int SBG_RX_DISABLE_BIT = 5;
   localparam int SBG_TX_ENABLE_BIT = 6;
   localparam int SBG_TX_DISABLE_BIT = 7;
   // Mode register fields.
   localparam int SBG_OPMODE_LSB = 0;
   localparam int SBG_CLKSEL_LSB = 4;
   localparam int SBG_SYNC_BIT = 8;
   localparam int SBG_CARD_CLOCK_OUT_EN_BIT = 18;
   localparam int SBG_OVER_BIT = 19;
   // Bit rate generator register fields.
   localparam int SBG_CD_LSB = 0;
   localparam int SBG_FP_LSB = 16;
   // Field widths.
   localparam int SBG_CD_W = 16;
   localparam int SBG_FP_W = 3;
   localparam int SBG_ETU_W = 11;
   // Operating mode codes.
   localparam logic [3:0] SBG_OPMODE_NORMAL = 4'h0;
   localparam logic [3:0] SBG_OPMODE_ISO_T0 = 4'h4;
   localparam logic [3:0] SBG_OPMODE_ISO_T1 = 4'h6;
   // Clock source codes.
   localparam logic [1:0] SBG_SRC_MCK = 2'h0;
   localparam logic [1:0] SBG_SRC_MCK_DIV = 2'h1;
   localparam logic [1:0] SBG_SRC_EXT = 2'h3;
   // Prescaler of the divided master clock, last count of a divide by 8.
   localparam logic [2:0] SBG_PRE_LAST = 3'h7;
   // Oversampling last counts for divide by 16 and divide by 8.
   localparam logic [3:0] SBG_OS16_LAST = 4'hF;
   localparam logic [3:0] SBG_OS8_LAST = 4'h7;
   // Reset values.
   localparam logic [SBG_ETU_W-1:0] SBG_ETU_RST = 11'h174;
   localparam logic [SBG_CD_W-1:0] SBG_CD_RST = 16'h0000;
   localparam logic [SBG_FP_W-1:0] SBG_FP_RST = 3'h0;
   localparam logic [3:0] SBG_OPMODE_RST = 4'h0;
   localparam logic [1:0] SBG_CLKSEL_RST = 2'h0;
endpackage

// *** test/sbg_properties.sv ***
// Checker of bus timing, channel enables and soft reset pulses.
`timescale 1ns/1ps
module sbg_props_chk import sbg_pkg::*; (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Register bus.
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Serial clock pin.
   input wire logic sck_i,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   // Framing side.
   input wire logic rx_busy_i,
   input wire logic tx_busy_i,
   input wire logic rx_en_o,
   input wire logic tx_en_o,
   input wire logic rx_soft_reset_o,
   input wire logic tx_soft_reset_o,
   input wire logic samp_tick_o,
   input wire logic baud_tick_o
);
   // A control write counts at the edge where waitrequest is low.
   wire logic req = avs_read_i | avs_write_i;
   wire logic cw = avs_write_i && !avs_waitrequest_o &&
      avs_address_i == SBG_CTRL_OFS && avs_byteenable_i[0];
   wire logic [7:0] d = avs_writedata_i[7:0];

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Every access gets exactly one wait state.
   wait_state_a: assert property ($rose(req) |->
      avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("Bus wait state is wrong.");
   // Enable commands take effect one cycle after the write.
   rx_enable_a: assert property (
      cw && d[4] && !d[5] |=> rx_en_o)
      else $error("Receiver did not start.");
   tx_enable_a: assert property (
      cw && d[6] && !d[7] |=> tx_en_o)
      else $error("Transmitter did not start.");
   // An idle receiver stops two cycles after the disable.
   rx_dis_idle_a: assert property (
      cw && d[5] && !rx_busy_i ##1 !rx_busy_i |=> !rx_en_o)
      else $error("Idle receiver did not stop.");
   // A channel stops while its character is in flight only around a soft reset pulse.
   rx_dis_wait_a: assert property (
      $fell(rx_en_o) |-> !$past(rx_busy_i) || rx_soft_reset_o ||
      $past(rx_soft_reset_o))
      else $error("Receiver stopped mid character.");
   tx_dis_wait_a: assert property (
      $fell(tx_en_o) |-> !$past(tx_busy_i) || tx_soft_reset_o ||
      $past(tx_soft_reset_o))
      else $error("Transmitter stopped while busy.");
   // Soft reset commands give a single cycle pulse.
   rx_srst_a: assert property (
      cw && d[2] |=> rx_soft_reset_o ##1 !rx_soft_reset_o)
      else $error("Receiver reset pulse wrong.");
   tx_srst_a: assert property (
      cw && d[3] |=> tx_soft_reset_o ##1 !tx_soft_reset_o)
      else $error("Transmitter reset pulse wrong.");

   // Main scenarios reached.
   cover property ($fell(rx_en_o));
   cover property (baud_tick_o);
   cover property (sck_oe_o);
endmodule

// *** test/sbg_sck_peer.sv ***
// Remote party that drives the external serial clock pin.
`timescale 1ns/1ps
module sbg_sck_peer #(
   parameter int HALF_NS = 125,
   parameter int SKEW_NS = 5
) (
   // Run request from the bench.
   input wire logic run_i,
   // Clock onto the pin.
   output logic sck_o
);
   // Toggles only while running, rests low between bursts.
   // Each burst starts off the system clock edges to avoid a race.
   initial begin
      sck_o = 1'b0;
      forever begin
         wait (run_i === 1'b1);
         #(SKEW_NS);
         while (run_i === 1'b1) begin
            #(HALF_NS) sck_o = 1'b1;
            #(HALF_NS) sck_o = 1'b0;
         end
      end
   end
endmodule

// *** test/tb_top.sv ***
// Self-checking bench of the bit clock generator and channel control.
`timescale 1ns/1ps
module tb_top;
   import sbg_pkg::*;
   // One rate case: mode, divider, ratio, tick watched, span of 8.
   typedef struct {
      logic [31:0] mode;
      logic [31:0] brgr;
      logic [31:0] etu;
      logic baud;
      int span;
   } sbg_tcase_type;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o, sck_i, sck_o, sck_oe_o;
   logic rx_busy_i = 1'b0;
   logic tx_busy_i = 1'b0;
   logic rx_en_o, tx_en_o, rx_soft_reset_o, tx_soft_reset_o;
   logic samp_tick_o, baud_tick_o;
   logic peer_run = 1'b0;
   int fail_count = 0;
   int samples_checked = 0;
   sbg_tcase_type tc [12] = '{
      '{32'h0, 32'h0, 32'h174, 1'b0, 0},
      '{32'h0, 32'h1, 32'h174, 1'b0, 8},
      '{32'h0, 32'h3, 32'h174, 1'b0, 24},
      '{32'h0, 32'h3, 32'h174, 1'b1, 384},
      '{32'h80000, 32'h3, 32'h174, 1'b1, 192},
      '{32'h10, 32'h2, 32'h174, 1'b0, 128},
      '{32'h0, 32'h40002, 32'h174, 1'b0, 20},
      '{32'h80000, 32'h40002, 32'h174, 1'b1, 160},
      '{32'h4, 32'h40002, 32'h10, 1'b0, 16},
      '{32'h4, 32'h40002, 32'h10, 1'b1, 256},
      '{32'h100, 32'h5, 32'h174, 1'b1, 40},
      '{32'h130, 32'h5, 32'h174, 1'b1, 80}};

   sbg_ctrl dut (.*);
   sbg_sck_peer #(.HALF_NS(125)) peer (.run_i(peer_run), .sck_o(sck_i));

   // Free running system clock.
   initial begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   // Counts a comparison and reports a mismatch.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One bus access, held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      do begin
         @(posedge sys_clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, e);
   endtask

   // Cycles from the second to the tenth tick of the chosen output.
   task automatic span(input logic b, output int c);
      int k, t;
      k = 0;
      c = 0;
      t = 0;
      while (k < 10 && t < 5000) begin
         @(negedge sys_clk_i);
         t++;
         if (k >= 2) c++;
         if ((b ? baud_tick_o : samp_tick_o) === 1'b1) k++;
      end
   endtask

   // Checks both enable outputs at a settled point.
   task automatic en_chk(input logic [31:0] e);
      @(negedge sys_clk_i);
      check({30'h0, tx_en_o, rx_en_o}, e);
      @(posedge sys_clk_i);
   endtask

   // Reset values, field widths and refused addresses.
   task automatic t_regs();
      rd_chk(SBG_FIDI_OFS, 32'h174);
      rd_chk(SBG_STAT_OFS, 32'h0);
      wr(SBG_BRGR_OFS, 32'hFFFFFFFF);
      rd_chk(SBG_BRGR_OFS, 32'h7FFFF);
      wr(SBG_FIDI_OFS, 32'hFFFFFFFF);
      rd_chk(SBG_FIDI_OFS, 32'h7FF);
      wr(8'h08, 32'hFFFFFFFF);
      rd_chk(8'h08, 32'h0);
      rd_chk(SBG_CTRL_OFS, 32'h0);
   endtask

   // Tick spacing for every source, mode and divider case.
   task automatic t_rates();
      int got;
      for (int i = 0; i < 12; i++) begin
         wr(SBG_MODE_OFS, tc[i].mode);
         wr(SBG_FIDI_OFS, tc[i].etu);
         wr(SBG_BRGR_OFS, tc[i].brgr);
         peer_run <= (tc[i].mode[5:4] == 2'h3);
         span(tc[i].baud, got);
         check(got, tc[i].span);
         peer_run <= 1'b0;
      end
   endtask

   // Card clock on the pin with an odd divisor from the master clock.
   task automatic t_duty();
      int h;
      h = 0;
      wr(SBG_BRGR_OFS, 32'h3);
      wr(SBG_MODE_OFS, 32'h40004);
      @(negedge sys_clk_i);
      check({31'h0, sck_oe_o}, 32'h1);
      repeat (48) begin
         @(sys_clk_i);
         #1;
         h += (sck_o === 1'b1);
      end
      check(h, 24);
      rd_chk(SBG_MODE_OFS, 32'h40004);
   endtask

   // Enables, delayed disables and soft reset.
   task automatic t_enable();
      wr(SBG_CTRL_OFS, 32'h10);
      rd_chk(SBG_STAT_OFS, 32'h1);
      wr(SBG_CTRL_OFS, 32'h40);
      rd_chk(SBG_STAT_OFS, 32'h3);
      rx_busy_i <= 1'b1;
      tx_busy_i <= 1'b1;
      wr(SBG_CTRL_OFS, 32'hA0);
      rd_chk(SBG_STAT_OFS, 32'hF);
      repeat (6) @(posedge sys_clk_i);
      en_chk(32'h3);
      rx_busy_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      en_chk(32'h2);
      tx_busy_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      en_chk(32'h0);
      wr(SBG_CTRL_OFS, 32'h10);
      wr(SBG_CTRL_OFS, 32'h0C);
      @(negedge sys_clk_i);
      check({30'h0, tx_soft_reset_o, rx_soft_reset_o}, 32'h3);
      rd_chk(SBG_BRGR_OFS, 32'h3);
      rd_chk(SBG_STAT_OFS, 32'h1);
      wr(SBG_CTRL_OFS, 32'h20);
      rd_chk(SBG_STAT_OFS, 32'h0);
   endtask

   // Prints the verdict and ends the run.
   task automatic test_done();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Main sequence after four reset cycles.
   initial begin
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_rates();
      t_duty();
      t_enable();
      test_done();
   end

   // Watchdog well beyond the expected run length.
   initial begin
      #(25 * 80000);
      fail_count++;
      test_done();
   end
endmodule

bind sbg_ctrl sbg_props_chk chk (.*);
